/* inc/btmc_pkg.sv */
// Constants, field layouts and state codes of the bank timing controller.
// Assumes bit positions are given little-endian: index 0 is the word's LSB.
package btmc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [3:0] BTMC_OFS_STATIC = 4'h0;
  localparam logic [3:0] BTMC_OFS_DYNAMIC = 4'h4;
  localparam logic [3:0] BTMC_OFS_IOCFG = 4'h8;
  localparam logic [3:0] BTMC_OFS_STATUS = 4'hC;

  // ****************************************************************
  // Static bank fields
  // ****************************************************************
  localparam int BTMC_S_LINE_FILL = 18;
  localparam int BTMC_S_BURST = 17;
  localparam int BTMC_S_WID_HI = 16;
  localparam int BTMC_S_WID_LO = 15;
  localparam int BTMC_S_RDY_EN = 14;
  localparam int BTMC_S_WAIT_HI = 13;
  localparam int BTMC_S_WAIT_LO = 8;
  localparam int BTMC_S_BWAIT_LO = 10;
  localparam int BTMC_S_BBEAT_HI = 9;
  localparam int BTMC_S_BBEAT_LO = 8;
  localparam int BTMC_S_CSD = 7;
  localparam int BTMC_S_OED = 6;
  localparam int BTMC_S_WR_ON = 5;
  localparam int BTMC_S_WR_OFF = 4;
  localparam int BTMC_S_HOLD_HI = 3;
  localparam int BTMC_S_HOLD_LO = 1;

  // ****************************************************************
  // Dynamic bank fields
  // ****************************************************************
  localparam int BTMC_D_EARLY_ROW = 17;
  localparam int BTMC_D_EXTMUX = 14;
  localparam int BTMC_D_RCD = 13;
  localparam int BTMC_D_RFM = 12;
  localparam int BTMC_D_PAGE = 11;
  localparam int BTMC_D_FA_HI = 10;
  localparam int BTMC_D_FA_LO = 9;
  localparam int BTMC_D_BA_HI = 8;
  localparam int BTMC_D_BA_LO = 7;

  // ****************************************************************
  // I/O configuration and status bits
  // ****************************************************************
  localparam int BTMC_IO_RDY_ASYNC = 0;
  localparam int BTMC_IO_TMO_DIS = 1;
  localparam int BTMC_IO_RW_BE = 2;
  localparam int BTMC_ST_TMO = 0;
  localparam int BTMC_ST_BUSY = 1;

  localparam logic [31:0] BTMC_STATIC_RST = 32'h0000_0002;
  localparam logic [31:0] BTMC_DYNAMIC_RST = 32'h0000_0000;
  localparam logic [31:0] BTMC_IOCFG_RST = 32'h0000_0000;

  // ****************************************************************
  // Encodings and timing
  // ****************************************************************
  localparam logic [1:0] BTMC_WID_BYTE = 2'h0;
  localparam logic [1:0] BTMC_WID_HALF = 2'h1;
  localparam logic [1:0] BTMC_WID_WORD = 2'h2;
  localparam logic [2:0] BTMC_HOLD_MIN = 3'h1;
  localparam logic [1:0] BTMC_SYNC_DLY = 2'h0;
  localparam logic [1:0] BTMC_ASYNC_DLY = 2'h2;
  localparam int BTMC_TIMEOUT_CYCLES = 128;

  typedef enum logic [6:0] {
    BTMC_ST_IDLE = 7'h01,
    BTMC_ST_SACC = 7'h02,
    BTMC_ST_SRDY = 7'h04,
    BTMC_ST_SSYN = 7'h08,
    BTMC_ST_HOLD = 7'h10,
    BTMC_ST_DROW = 7'h20,
    BTMC_ST_DCOL = 7'h40
  } btmc_state_t;

endpackage : btmc_pkg

/* hdl/btmc_controller.sv */
// Bank timing controller: sequences SRAM/ROM/IO and DRAM page accesses.
// Assumes all inputs are synchronous to CORE_CLK and registers are set
// before the first request.
//
// Functional notes
// - read wait covers delays; outputs then hold
// - hold above minimum freezes outputs longer
// - zero wait ignores ready, single cycle
// - ready sampled from wait end onward
// - synchronous ready captures data next cycle
// - asynchronous ready transfers on third cycle
// - no ready by limit ends with error
// - narrow banks put address on enables 2,3
// - DRAM keeps enables 0,1 high throughout
// - config bit picks write-only or read-write enables
// - internal mux keeps top address pins unmultiplexed
// - external mux leaves lower pins unchanged
// - DRAM bursts fetch target word first
// - static config holds all listed fields
// - burst mode splits wait and beat wait
// - dynamic config holds all listed fields
// - page timing gives 2-1-1-1 or 3-2-2-2
// - ready enable stretches read until ready
// - row and column bits follow pin mapping
// - static word bank enables select lanes 0 to 3
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
module btmc_controller
  import btmc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = btmc_pkg::BTMC_TIMEOUT_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_DRAM,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [1:0] REQ_SIZE,
  input wire logic [1:0] REQ_BEATS,
  input wire logic [31:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [31:0] RSP_RDATA,
  output logic RSP_DONE,
  output logic RSP_ERR,
  output logic [23:0] EXT_ADDR,
  output logic EXT_CS_N,
  output logic EXT_OE_N,
  output logic EXT_WE_N,
  output logic EXT_RAS_N,
  output logic EXT_CAS_N,
  output logic [3:0] EXT_BE_N,
  output logic [31:0] EXT_DQ_O,
  output logic EXT_DQ_OE,
  input wire logic [31:0] EXT_DQ_I,
  input wire logic EXT_READY
);
  import btmc_pkg::*;

  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 256) begin : g_chk
    $error("TIMEOUT_CYCLES must lie in 2..256");
  end

  localparam logic [7:0] TMO_LAST = 8'(TIMEOUT_CYCLES - 1);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    btmc_state_t st;
    logic [31:0] scfg;
    logic [31:0] dcfg;
    logic [31:0] iocfg;
    logic tmo;
    logic avs_wait;
    logic [31:0] avs_rdata;
    logic [5:0] cnt;
    logic [5:0] lim;
    logic [7:0] cyc;
    logic [1:0] dly;
    logic [2:0] hcnt;
    logic [1:0] beat;
    logic [1:0] nbeat;
    logic [31:0] addr;
    logic wr;
    logic [1:0] size;
    logic dram;
    logic req_ready;
    logic rsp_valid;
    logic [31:0] rsp_rdata;
    logic rsp_done;
    logic rsp_err;
    logic [23:0] addr_o;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic ras_n;
    logic cas_n;
    logic [3:0] be_n;
    logic [31:0] dq_o;
    logic dq_oe;
  } btmc_regs_t;

  btmc_regs_t s_reg;
  btmc_regs_t s_next;
  logic cap;
  logic rdy_hit;
  logic tmo_fire;
  logic need_rdy;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Returns {cs, oe, we}, active high, for cycle c of a first beat.
  function automatic logic [2:0] sram_strobes(input logic [5:0] c,
      input logic [31:0] cfg, input logic wr, input logic [5:0] w);
    logic [6:0] cs_at;
    logic [6:0] oe_at;
    logic [6:0] we_at;
    cs_at = {6'h00, cfg[BTMC_S_CSD]};
    oe_at = cs_at + {6'h00, cfg[BTMC_S_OED]};
    we_at = cs_at + {6'h00, cfg[BTMC_S_WR_ON]};
    sram_strobes[2] = {1'h0, c} >= cs_at;
    sram_strobes[1] = !wr && ({1'h0, c} >= oe_at);
    sram_strobes[0] = wr && ({1'h0, c} >= we_at) &&
        ({1'h0, c} + {6'h00, cfg[BTMC_S_WR_OFF]} <= {1'h0, w});
  endfunction : sram_strobes

  // Active-low enables; index 0 is enable line 0.
  function automatic logic [3:0] byte_en_n(input logic [1:0] wid,
      input logic [1:0] size, input logic [1:0] a);
    byte_en_n = {a[0], a[1], 2'h3};
    if (wid == BTMC_WID_BYTE) begin
      byte_en_n[1:0] = 2'h2;
    end else if (wid == BTMC_WID_HALF) begin
      byte_en_n[1:0] = (size == BTMC_WID_BYTE) ? {!a[0], a[0]} : 2'h0;
    end else if (size == BTMC_WID_WORD) begin
      byte_en_n = 4'h0;
    end else if (size == BTMC_WID_HALF) begin
      byte_en_n = a[1] ? 4'h3 : 4'hC;
    end else begin
      byte_en_n = ~(4'h1 << a);
    end
  endfunction : byte_en_n

  // Multiplexed DRAM address; bit i of the result drives pin A(29-i).
  function automatic logic [23:0] dram_addr(input logic [31:0] a,
      input logic row);
    int k;
    dram_addr = a[25:2];
    for (int i = 0; i < 19; i++) begin
      k = 29 - i;
      if (row) begin
        dram_addr[i] = (k <= 18) ? a[36 - k] : a[38 - k];
      end else if (k != 11) begin
        dram_addr[i] = (k <= 18) ? a[37 - k] : a[29 - k];
      end
    end
  endfunction : dram_addr

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8 * i +: 8] = be[i] ? d[8 * i +: 8] : old[8 * i +: 8];
    end
  endfunction : merge

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [5:0] s_wait;
    logic [1:0] wid;
    logic [2:0] stb;
    logic [3:0] be;
    s_next = s_reg;
    s_wait = s_reg.scfg[BTMC_S_BURST] ?
        {2'h0, s_reg.scfg[BTMC_S_WAIT_HI:BTMC_S_WAIT_LO + 2]} :
        s_reg.scfg[BTMC_S_WAIT_HI:BTMC_S_WAIT_LO];
    wid = BTMC_WID_WORD;
    stb = 3'h0;
    be = 4'hF;
    s_next.rsp_valid = 1'h0;
    s_next.rsp_done = 1'h0;
    s_next.rsp_err = 1'h0;
    cap = 1'h0;
    tmo_fire = 1'h0;
    // Ready only paces the first beat, and never a zero-wait access.
    need_rdy = s_reg.scfg[BTMC_S_RDY_EN] && (s_wait != 6'h00) &&
        (s_reg.beat == 2'h0);
    rdy_hit = EXT_READY && ((s_reg.st == BTMC_ST_SRDY) ||
        (s_reg.st == BTMC_ST_SACC && s_reg.cnt == s_reg.lim && need_rdy));

    // Slave answers one cycle after the request; effects at that edge.
    s_next.avs_wait = 1'h1;
    if ((AVS_READ || AVS_WRITE) && s_reg.avs_wait) begin
      s_next.avs_wait = 1'h0;
      case (AVS_ADDRESS)
        BTMC_OFS_STATIC: s_next.avs_rdata = s_reg.scfg;
        BTMC_OFS_DYNAMIC: s_next.avs_rdata = s_reg.dcfg;
        BTMC_OFS_IOCFG: s_next.avs_rdata = s_reg.iocfg;
        BTMC_OFS_STATUS: s_next.avs_rdata = {30'h0,
            s_reg.st != BTMC_ST_IDLE, s_reg.tmo};
        default: s_next.avs_rdata = 32'h0000_0000;
      endcase
    end
    if (AVS_WRITE && !s_reg.avs_wait) begin
      case (AVS_ADDRESS)
        BTMC_OFS_STATIC: s_next.scfg =
            merge(s_reg.scfg, AVS_WRITEDATA, AVS_BYTEENABLE);
        BTMC_OFS_DYNAMIC: s_next.dcfg =
            merge(s_reg.dcfg, AVS_WRITEDATA, AVS_BYTEENABLE);
        BTMC_OFS_IOCFG: s_next.iocfg =
            merge(s_reg.iocfg, AVS_WRITEDATA, AVS_BYTEENABLE);
        BTMC_OFS_STATUS: begin
          if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[BTMC_ST_TMO]) begin
            s_next.tmo = 1'h0;
          end
        end
        default: s_next.tmo = s_reg.tmo;
      endcase
    end

    case (s_reg.st)
      BTMC_ST_IDLE: begin
        if (REQ_VALID && s_reg.req_ready) begin
          s_next.req_ready = 1'h0;
          s_next.addr = REQ_ADDR;
          s_next.wr = REQ_WRITE;
          s_next.size = REQ_SIZE;
          s_next.dram = REQ_DRAM;
          s_next.beat = 2'h0;
          s_next.cnt = 6'h00;
          s_next.cyc = 8'h00;
          s_next.dq_o = REQ_WDATA;
          s_next.dq_oe = REQ_WRITE;
          s_next.nbeat = (REQ_DRAM || s_reg.scfg[BTMC_S_BURST]) ?
              REQ_BEATS : 2'h0;
          if (REQ_DRAM) begin
            s_next.st = BTMC_ST_DROW;
            s_next.lim = {4'h0, s_reg.dcfg[BTMC_D_FA_HI:BTMC_D_FA_LO]} +
                {5'h00, s_reg.dcfg[BTMC_D_RCD]};
          end else begin
            s_next.st = BTMC_ST_SACC;
            s_next.lim = s_wait;
          end
        end
      end
      BTMC_ST_SACC: begin
        s_next.cyc = s_reg.cyc + 8'h01;
        if (s_reg.cnt != s_reg.lim) begin
          s_next.cnt = s_reg.cnt + 6'h01;
        end else if (!need_rdy) begin
          cap = 1'h1;
        end else if (EXT_READY) begin
          s_next.st = BTMC_ST_SSYN;
          s_next.dly = s_reg.iocfg[BTMC_IO_RDY_ASYNC] ?
              BTMC_ASYNC_DLY : BTMC_SYNC_DLY;
        end else begin
          s_next.st = BTMC_ST_SRDY;
        end
      end
      BTMC_ST_SRDY: begin
        s_next.cyc = s_reg.cyc + 8'h01;
        if (EXT_READY) begin
          s_next.st = BTMC_ST_SSYN;
          s_next.dly = s_reg.iocfg[BTMC_IO_RDY_ASYNC] ?
              BTMC_ASYNC_DLY : BTMC_SYNC_DLY;
        end else if (s_reg.cyc >= TMO_LAST &&
            !s_reg.iocfg[BTMC_IO_TMO_DIS]) begin
          tmo_fire = 1'h1;
        end
      end
      BTMC_ST_SSYN: begin
        if (s_reg.dly == 2'h0) begin
          cap = 1'h1;
        end else begin
          s_next.dly = s_reg.dly - 2'h1;
        end
      end
      BTMC_ST_HOLD: begin
        if (s_reg.hcnt > BTMC_HOLD_MIN) begin
          s_next.hcnt = s_reg.hcnt - 3'h1;
        end else begin
          s_next.st = BTMC_ST_IDLE;
        end
      end
      BTMC_ST_DROW: begin
        if (s_reg.cnt != s_reg.lim) begin
          s_next.cnt = s_reg.cnt + 6'h01;
        end else begin
          s_next.st = BTMC_ST_DCOL;
          s_next.cnt = 6'h00;
          s_next.lim = 6'h00;
        end
      end
      BTMC_ST_DCOL: begin
        if (s_reg.cnt != s_reg.lim) begin
          s_next.cnt = s_reg.cnt + 6'h01;
        end else begin
          cap = 1'h1;
        end
      end
      default: s_next.st = BTMC_ST_IDLE;
    endcase

    if (cap) begin
      s_next.rsp_valid = 1'h1;
      if (!s_reg.wr) begin
        s_next.rsp_rdata = EXT_DQ_I;
      end
      if (s_reg.beat != s_reg.nbeat) begin
        // Wrapping order keeps the target word first in the burst.
        s_next.beat = s_reg.beat + 2'h1;
        s_next.addr[3:2] = s_reg.addr[3:2] + 2'h1;
        s_next.dq_o = REQ_WDATA;
        s_next.cnt = 6'h00;
        if (!s_reg.dram) begin
          s_next.st = BTMC_ST_SACC;
          s_next.lim = {4'h0,
              s_reg.scfg[BTMC_S_BBEAT_HI:BTMC_S_BBEAT_LO]};
        end else if (s_reg.dcfg[BTMC_D_PAGE]) begin
          s_next.st = BTMC_ST_DCOL;
          s_next.lim = {4'h0,
              s_reg.dcfg[BTMC_D_BA_HI:BTMC_D_BA_LO]};
        end else begin
          s_next.st = BTMC_ST_DROW;
          s_next.lim = {4'h0, s_reg.dcfg[BTMC_D_FA_HI:BTMC_D_FA_LO]} +
              {5'h00, s_reg.dcfg[BTMC_D_RCD]};
        end
      end else if (!s_reg.dram && s_reg.scfg[BTMC_S_HOLD_HI:
          BTMC_S_HOLD_LO] > BTMC_HOLD_MIN) begin
        s_next.st = BTMC_ST_HOLD;
        s_next.hcnt = s_reg.scfg[BTMC_S_HOLD_HI:BTMC_S_HOLD_LO];
      end else begin
        s_next.st = BTMC_ST_IDLE;
      end
    end
    if (tmo_fire) begin
      s_next.st = BTMC_ST_IDLE;
      s_next.rsp_err = 1'h1;
      s_next.tmo = 1'h1;
    end
    if (s_next.st == BTMC_ST_IDLE && s_reg.st != BTMC_ST_IDLE) begin
      s_next.rsp_done = 1'h1;
      s_next.req_ready = 1'h1;
    end

    // Pin values follow the state that is entered.
    // Width comes from the bank being entered, not the previous access.
    wid = s_next.dram ? s_reg.dcfg[BTMC_S_WID_HI:BTMC_S_WID_LO] :
        s_reg.scfg[BTMC_S_WID_HI:BTMC_S_WID_LO];
    be = byte_en_n(wid, s_next.size, s_next.addr[1:0]);
    case (s_next.st)
      BTMC_ST_IDLE: begin
        s_next.cs_n = 1'h1;
        s_next.oe_n = 1'h1;
        s_next.we_n = 1'h1;
        s_next.ras_n = 1'h1;
        s_next.cas_n = 1'h1;
        s_next.be_n = 4'hF;
        s_next.dq_oe = 1'h0;
      end
      BTMC_ST_SACC: begin
        if (s_next.beat == 2'h0) begin
          stb = sram_strobes(s_next.cnt, s_reg.scfg, s_next.wr,
              s_next.lim);
        end else begin
          stb = {1'h1, !s_next.wr, s_next.wr};
        end
        s_next.cs_n = !stb[2];
        s_next.oe_n = !stb[1];
        s_next.we_n = !stb[0];
        s_next.addr_o = s_next.addr[25:2];
        // Read-write enables follow chip select; write-only ones the write strobe.
        s_next.be_n = (s_reg.iocfg[BTMC_IO_RW_BE] ? stb[2] : stb[0]) ?
            be : 4'hF;
        if (wid != BTMC_WID_WORD) begin
          s_next.be_n[3:2] = be[3:2];
        end
      end
      BTMC_ST_DROW, BTMC_ST_DCOL: begin
        s_next.ras_n = 1'h0;
        s_next.cas_n = s_next.st != BTMC_ST_DCOL;
        s_next.oe_n = s_next.wr || s_next.cas_n;
        s_next.we_n = !s_next.wr || s_next.cas_n;
        s_next.be_n = {(wid != BTMC_WID_WORD) ? be[3:2] : 2'h3,
            2'h3};
        s_next.addr_o = s_reg.dcfg[BTMC_D_EXTMUX] ? s_next.addr[25:2] :
            dram_addr(s_next.addr, s_next.cas_n);
      end
      default: s_next.be_n = s_next.be_n;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_reg <= '0;
      s_reg.st <= BTMC_ST_IDLE;
      s_reg.scfg <= BTMC_STATIC_RST;
      s_reg.dcfg <= BTMC_DYNAMIC_RST;
      s_reg.iocfg <= BTMC_IOCFG_RST;
      s_reg.avs_wait <= 1'h1;
      s_reg.req_ready <= 1'h1;
      s_reg.cs_n <= 1'h1;
      s_reg.oe_n <= 1'h1;
      s_reg.we_n <= 1'h1;
      s_reg.ras_n <= 1'h1;
      s_reg.cas_n <= 1'h1;
      s_reg.be_n <= 4'hF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign AVS_READDATA = s_reg.avs_rdata;
  assign AVS_WAITREQUEST = s_reg.avs_wait;
  assign REQ_READY = s_reg.req_ready;
  assign RSP_VALID = s_reg.rsp_valid;
  assign RSP_RDATA = s_reg.rsp_rdata;
  assign RSP_DONE = s_reg.rsp_done;
  assign RSP_ERR = s_reg.rsp_err;
  assign EXT_ADDR = s_reg.addr_o;
  assign EXT_CS_N = s_reg.cs_n;
  assign EXT_OE_N = s_reg.oe_n;
  assign EXT_WE_N = s_reg.we_n;
  assign EXT_RAS_N = s_reg.ras_n;
  assign EXT_CAS_N = s_reg.cas_n;
  assign EXT_BE_N = s_reg.be_n;
  assign EXT_DQ_O = s_reg.dq_o;
  assign EXT_DQ_OE = s_reg.dq_oe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence async_transfer;
    !cap ##1 !cap ##1 cap;
  endsequence
  sequence three_cycle_first;
    !cap ##1 cap;
  endsequence

  AST_ZERO_WAIT: assert property (s_reg.st == BTMC_ST_SACC &&
      s_reg.beat == 2'h0 && s_reg.lim == 6'h00 |-> cap)
    else $error("zero wait access did not finish in one cycle");
  AST_READY_EARLY: assert property (s_reg.st == BTMC_ST_SACC &&
      s_reg.cnt != s_reg.lim |-> !rdy_hit && !cap)
    else $error("ready sampled before wait elapsed");
  AST_SYNC_READY: assert property (rdy_hit &&
      !s_reg.iocfg[BTMC_IO_RDY_ASYNC] |=> cap)
    else $error("sync ready capture not one cycle later");
  AST_ASYNC_READY: assert property (rdy_hit &&
      s_reg.iocfg[BTMC_IO_RDY_ASYNC] |=> async_transfer)
    else $error("async ready transfer not in third cycle");
  AST_TIMEOUT: assert property (tmo_fire |=>
      s_reg.rsp_err && s_reg.rsp_done && s_reg.tmo && s_reg.cs_n)
    else $error("timeout did not end the access with error");
  AST_HOLD: assert property (s_reg.st == BTMC_ST_HOLD &&
      s_reg.hcnt > BTMC_HOLD_MIN |=> $stable({s_reg.cs_n, s_reg.oe_n,
      s_reg.we_n, s_reg.be_n, s_reg.addr_o}))
    else $error("outputs moved during hold");
  AST_DRAM_BE: assert property (s_reg.st inside {BTMC_ST_DROW,
      BTMC_ST_DCOL} |-> s_reg.be_n[1:0] == 2'h3)
    else $error("low enables not high in DRAM access");
  AST_NARROW_BE: assert property (s_reg.st != BTMC_ST_IDLE &&
      s_reg.scfg[BTMC_S_WID_HI:BTMC_S_WID_LO] != BTMC_WID_WORD &&
      !s_reg.dram |-> s_reg.be_n[3:2] == {s_reg.addr[0], s_reg.addr[1]})
    else $error("narrow bank enables lack address bits");
  AST_INT_MUX: assert property (s_reg.st == BTMC_ST_DCOL &&
      !s_reg.dcfg[BTMC_D_EXTMUX] |-> s_reg.addr_o[23:19] ==
      s_reg.addr[25:21])
    else $error("top address pins multiplexed");
  AST_EXT_MUX: assert property (s_reg.st inside {BTMC_ST_DROW,
      BTMC_ST_DCOL} && s_reg.dcfg[BTMC_D_EXTMUX] |->
      s_reg.addr_o == s_reg.addr[25:2])
    else $error("external mux address changed");
  AST_PAGE_2111: assert property (s_reg.st == BTMC_ST_DROW &&
      s_reg.cnt == 6'h00 && s_reg.lim == 6'h00 |=> cap)
    else $error("two cycle first access broken");
  AST_PAGE_3222: assert property (s_reg.st == BTMC_ST_DROW &&
      s_reg.cnt == 6'h00 && s_reg.lim == 6'h01 |=> three_cycle_first)
    else $error("three cycle first access broken");

endmodule : btmc_controller

/* verification/btmc_mem_model.sv */
// External memory and ready source seen by the bank controller.
// Assumes registered strobes from the controller on the same clock.
module btmc_mem_model (
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [31:0] dq_o,
  input wire logic dq_oe,
  input wire logic [7:0] rdy_dly,
  output logic [31:0] dq_i,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:3];
  logic [7:0] cnt;
  wire sel = !cs_n || !ras_n;
  // DRAM data moves only while the column strobe is low.
  wire act = !cs_n || (!ras_n && !cas_n);
  always_ff @(posedge clk) begin
    cnt <= sel ? cnt + 8'h01 : 8'h00;
    if (act && !we_n && dq_oe) mem[addr[1:0]] <= dq_o;
  end
  // A released or contended bus shows a changing pattern, so stale data
  // passes only while cnt is 8'hFF.
  assign dq_i = (act && !oe_n && !dq_oe) ? mem[addr[1:0]] :
      ~mem[addr[1:0]] ^ {4{cnt}};
  // Ready comes rdy_dly cycles into the access; 8'hFF never answers.
  assign ready = sel && rdy_dly != 8'hFF && cnt >= rdy_dly;
endmodule : btmc_mem_model

/* verification/btmc_controller_tb.sv */
// Bench of the bank timing controller against a memory model.
// Assumes the hand-over timing of the controller and its register map.
`define CHK(nm, x, y) begin samples_checked++; if ((y) !== (x)) begin \
n_errors++; $display("Error %s exp %0h got %0h", nm, x, y); end end
module btmc_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import btmc_pkg::*;
  logic CORE_CLK = 1'h0, SYS_RST = 1'h1, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
  logic REQ_VALID = 1'h0, REQ_WRITE = 1'h0, REQ_DRAM = 1'h0;
  logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_WRITEDATA = 32'h0, REQ_ADDR = 32'h0, REQ_WDATA = 32'h0;
  logic [1:0] REQ_SIZE = 2'h2, REQ_BEATS = 2'h0;
  logic [31:0] AVS_READDATA, RSP_RDATA, EXT_DQ_O, EXT_DQ_I, q;
  logic AVS_WAITREQUEST, REQ_READY, RSP_VALID, RSP_DONE, RSP_ERR, e;
  logic EXT_CS_N, EXT_OE_N, EXT_WE_N, EXT_RAS_N, EXT_CAS_N;
  logic EXT_DQ_OE, EXT_READY;
  logic [23:0] EXT_ADDR;
  logic [3:0] EXT_BE_N, be_seen;
  logic [7:0] rdy_dly = 8'h00;
  int n_errors = 0, samples_checked = 0, n, n0;
  btmc_controller #(.TIMEOUT_CYCLES(8)) u_dut (.CORE_CLK, .SYS_RST,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE, .AVS_WRITEDATA,
    .AVS_READDATA, .AVS_WAITREQUEST, .REQ_VALID, .REQ_WRITE, .REQ_DRAM,
    .REQ_ADDR, .REQ_SIZE, .REQ_BEATS, .REQ_WDATA, .REQ_READY, .RSP_VALID,
    .RSP_RDATA, .RSP_DONE, .RSP_ERR, .EXT_ADDR, .EXT_CS_N, .EXT_OE_N,
    .EXT_WE_N, .EXT_RAS_N, .EXT_CAS_N, .EXT_BE_N, .EXT_DQ_O, .EXT_DQ_OE,
    .EXT_DQ_I, .EXT_READY);
  btmc_mem_model u_mem (.clk(CORE_CLK), .addr(EXT_ADDR), .cs_n(EXT_CS_N),
    .ras_n(EXT_RAS_N), .cas_n(EXT_CAS_N), .oe_n(EXT_OE_N),
    .we_n(EXT_WE_N), .dq_o(EXT_DQ_O), .dq_oe(EXT_DQ_OE),
    .rdy_dly, .dq_i(EXT_DQ_I), .ready(EXT_READY));
  initial forever #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
    be_seen <= (REQ_VALID && REQ_READY) ? 4'hF :
      be_seen & ((EXT_CS_N && EXT_RAS_N) ? 4'hF : EXT_BE_N);
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic hang;
    n_errors++;
    give_verdict();
  endtask : hang
  // Each task ends one idle edge after release, so no strobe is assigned
  // twice in one time step when calls follow back to back.
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    int i;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge CORE_CLK);
      if (AVS_WAITREQUEST === 1'h0) break;
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'h0;
    AVS_READ <= 1'h0;
    if (i == 20) hang();
    @(posedge CORE_CLK);
  endtask : bus
  task automatic acc(input logic w, input logic dr, input logic [31:0] a,
      input logic [1:0] sz, input logic [1:0] bt);
    int i;
    REQ_WRITE <= w;
    REQ_DRAM <= dr;
    REQ_ADDR <= a;
    REQ_SIZE <= sz;
    REQ_BEATS <= bt;
    REQ_WDATA <= a ^ 32'h5A5A_0F0F;
    REQ_VALID <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge CORE_CLK);
      if (REQ_READY === 1'h1) break;
    end
    REQ_VALID <= 1'h0;
    for (n = 0; n < 300; n++) begin
      @(posedge CORE_CLK);
      if (RSP_VALID === 1'h1) q = RSP_RDATA;
      if (RSP_DONE === 1'h1) break;
    end
    e = RSP_ERR;
    if (i == 20 || n == 300) hang();
    @(posedge CORE_CLK);
  endtask : acc
  initial begin
    repeat (2) @(posedge CORE_CLK);
    SYS_RST <= 1'h0;
    @(posedge CORE_CLK);
    for (int k = 0; k < 5; k++) begin
      bus(1'h0, 4'(k * 4 + k / 4), 32'h0);
      `CHK("reset", k ? 32'h0 : BTMC_STATIC_RST, q)
    end
    bus(1'h1, BTMC_OFS_STATIC, 32'h0007_FFFE);
    bus(1'h0, BTMC_OFS_STATIC, 32'h0);
    `CHK("static", 32'h0007_FFFE, q)
    bus(1'h1, BTMC_OFS_STATIC, 32'h0001_0002);
    acc(1'h1, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("be word", 4'h0, be_seen)
    acc(1'h0, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("rd wait0", 32'h5A5A_0F0B, q)
    `CHK("be rd", 4'hF, be_seen)
    n0 = n;
    bus(1'h1, BTMC_OFS_STATIC, 32'h0001_0006);
    acc(1'h0, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("hold", n0 + 3, n)
    rdy_dly <= 8'hFF;
    bus(1'h1, BTMC_OFS_STATIC, 32'h0001_4002);
    acc(1'h0, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("no rdy", n0, n)
    rdy_dly <= 8'h04;
    bus(1'h1, BTMC_OFS_STATIC, 32'h0001_4202);
    acc(1'h0, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("rdy rd", 32'h5A5A_0F0B, q)
    n0 = n;
    bus(1'h1, BTMC_OFS_IOCFG, 32'h1);
    acc(1'h0, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("async", n0 + 2, n)
    rdy_dly <= 8'hFF;
    bus(1'h1, BTMC_OFS_IOCFG, 32'h0);
    acc(1'h0, 1'h0, 32'h4, 2'h2, 2'h0);
    `CHK("timeout", 1'h1, e)
    bus(1'h0, BTMC_OFS_STATUS, 32'h0);
    `CHK("status", 1'h1, q[BTMC_ST_TMO])
    bus(1'h1, BTMC_OFS_STATUS, 32'h1);
    bus(1'h0, BTMC_OFS_STATUS, 32'h0);
    `CHK("cleared", 1'h0, q[BTMC_ST_TMO])
    bus(1'h1, BTMC_OFS_IOCFG, 32'h4);
    bus(1'h1, BTMC_OFS_STATIC, 32'h0001_0002);
    acc(1'h0, 1'h0, 32'h6, 2'h0, 2'h0);
    `CHK("be rw", 4'hB, be_seen)
    bus(1'h1, BTMC_OFS_IOCFG, 32'h0);
    bus(1'h1, BTMC_OFS_STATIC, 32'h0000_0002);
    acc(1'h1, 1'h0, 32'h7, 2'h0, 2'h0);
    `CHK("be byte", 4'hE, be_seen)
    bus(1'h1, BTMC_OFS_DYNAMIC, 32'h0001_4000);
    acc(1'h1, 1'h1, 32'h8, 2'h2, 2'h0);
    `CHK("be dram", 4'hF, be_seen)
    acc(1'h0, 1'h1, 32'h8, 2'h2, 2'h0);
    `CHK("dram rd", 32'h5A5A_0F07, q)
    bus(1'h1, BTMC_OFS_DYNAMIC, 32'h0001_4800);
    acc(1'h0, 1'h1, 32'h8, 2'h2, 2'h3);
    n0 = n;
    bus(1'h1, BTMC_OFS_DYNAMIC, 32'h0001_4A80);
    acc(1'h0, 1'h1, 32'h8, 2'h2, 2'h3);
    `CHK("page", n0 + 4, n)
    `CHK("burst", 32'h5A5A_0F08, q)
    bus(1'h1, BTMC_OFS_STATIC, 32'h0003_0002);
    acc(1'h1, 1'h0, 32'h0, 2'h2, 2'h3);
    acc(1'h0, 1'h0, 32'h0, 2'h2, 2'h3);
    `CHK("sburst", 32'h5A5A_0F0F, q)
    give_verdict();
  end
endmodule : btmc_controller_tb
